// ==== rtl/cms_cfg.svh ====
// timing counts and field constants for the cell monitor conversion sequencer
`ifndef CMS_CFG_SVH
`define CMS_CFG_SVH
`define CMS_CLK_MHZ 50
`define CMS_CHAN_NS 1000
`define CMS_CHAN_CYC ((`CMS_CHAN_NS * `CMS_CLK_MHZ + 999) / 1000)
`define CMS_SEL_ALL 2'h0
`define CMS_SEL_ODD 2'h1
`define CMS_SEL_CELLS 2'h2
`define CMS_SEL_SELFTEST 2'h3
`define CMS_FIRST_CH 4'h0
`define CMS_LAST_CELL 4'h5
`define CMS_LAST_CH 4'hb
`define CMS_CODE_W 12
`endif

// ==== rtl/cms_pkg.sv ====
// types shared by the conversion sequencer modules
package cms_pkg;
    typedef enum logic [1:0] {
        CMS_IDLE = 2'b00,
        CMS_ACQ = 2'b01,
        CMS_CONV = 2'b10
    } cms_state_t;
endpackage : cms_pkg

// ==== rtl/cms_slot_if.sv ====
// channel slot bus between the sequencer and its timer
`timescale 1ns/1ns
interface cms_slot_if;
    logic start;
    logic done;
    modport seq (output start, input done);
    modport tmr (input start, output done);
endinterface : cms_slot_if

// ==== rtl/cms_slot_timer.sv ====
// per-channel acquire plus convert slot timer
`timescale 1ns/1ns
`include "cms_cfg.svh"
module cms_slot_timer import cms_pkg::*; #(
    parameter int CYC = `CMS_CHAN_CYC
) (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_ce,
    cms_slot_if.tmr slot
);
    typedef struct packed {
        logic [7:0] cnt;
        logic busy;
        logic done;
    } cms_tmr_t;
    cms_tmr_t s_q, s_d;
    // count out one channel slot, done pulses on the last cycle
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (slot.start) begin
            s_d.busy = 1'b1;
            s_d.cnt = 8'(CYC - 1);
        end else if (s_q.busy) begin
            if (s_q.cnt == 8'h01) begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
            end
            s_d.cnt = s_q.cnt - 8'h01;
        end
    end
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            s_q <= '0;
        end else if (i_ce) begin
            s_q <= s_d;
        end
    end
    assign slot.done = s_q.done;
endmodule : cms_slot_timer

// ==== rtl/cms_sequencer.sv ====
// conversion sequencer for a six-cell monitor with auxiliary inputs
`timescale 1ns/1ns
`include "cms_cfg.svh"
module cms_sequencer import cms_pkg::*; #(
    parameter int CW = `CMS_CODE_W
) (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_ce,
    input wire logic i_convert_start_n,
    input wire logic i_serial_start,
    input wire logic i_use_serial_start,
    input wire logic [1:0] i_channel_select_field,
    input wire logic [CW-1:0] i_adc_code,
    output logic o_busy,
    output logic o_seq_done,
    output logic o_sample,
    output logic [2:0] o_tap_hi,
    output logic [2:0] o_tap_lo,
    output logic o_aux_sel,
    output logic [2:0] o_temp_sense_sel,
    output logic [CW-1:0] o_result [12],
    output logic [11:0] o_result_valid
);
    typedef struct packed {
        logic [1:0] pin_sync;
        logic pin_prev;
        cms_state_t st;
        logic [3:0] ch;
        logic busy;
        logic seq_done;
        logic sample;
        logic [2:0] tap_hi;
        logic [2:0] tap_lo;
        logic aux_sel;
        logic [2:0] aux_idx;
        logic [11:0] valid;
    } cms_seq_t;
    cms_seq_t s_q, s_d;
    logic [CW-1:0] res_q [12];
    logic start_req;
    logic wr_en;
    cms_slot_if slot ();
    cms_slot_timer u_timer (
        .i_core_clk(i_core_clk),
        .i_reset_n(i_reset_n),
        .i_ce(i_ce),
        .slot(slot.tmr)
    );
    // next channel index after ch for the given selection, or an index past the last channel at end
    function automatic logic [3:0] next_ch(input logic [3:0] ch, input logic [1:0] sel);
        logic [3:0] n;
        n = ch + 4'h1;
        if (sel == `CMS_SEL_CELLS && ch == `CMS_LAST_CELL) n = `CMS_LAST_CH + 4'h1;
        if (sel == `CMS_SEL_ODD && ch > `CMS_LAST_CELL) n = ch + 4'h2;
        return n;
    endfunction : next_ch
    // channel index to mux setting: 0..5 cells 6..1, 6..11 aux 1..6
    function automatic logic [6:0] mux_of(input logic [3:0] ch);
        logic [2:0] hi;
        hi = 3'h6 - ch[2:0];
        if (ch > `CMS_LAST_CELL) return {1'b1, 3'(ch - 4'h6), hi};
        return {1'b0, 3'h0, hi};
    endfunction : mux_of
    // pin start takes only when selected; falling edge on the synced pin
    assign start_req = i_use_serial_start ? i_serial_start
        : (s_q.pin_prev && !s_q.pin_sync[1]);
    assign slot.start = s_d.st == CMS_ACQ && s_q.st != CMS_ACQ
        || (s_q.st == CMS_CONV && slot.done && s_d.st == CMS_ACQ);
    assign wr_en = s_q.st == CMS_CONV && slot.done;
    // sequence engine; timer done stands for the internal end of conversion
    always_comb begin
        logic [6:0] m;
        logic [3:0] n;
        m = '0;
        n = next_ch(s_q.ch, i_channel_select_field);
        s_d = s_q;
        s_d.pin_sync = {s_q.pin_sync[0], i_convert_start_n};
        s_d.pin_prev = s_q.pin_sync[1];
        s_d.seq_done = 1'b0;
        case (s_q.st)
            CMS_IDLE: begin
                // self-test code has no sequence here; it is simply not started
                if (start_req && i_channel_select_field != `CMS_SEL_SELFTEST) begin
                    s_d.st = CMS_ACQ;
                    s_d.ch = `CMS_FIRST_CH;
                    s_d.busy = 1'b1;
                    s_d.valid = '0;
                end
            end
            CMS_ACQ: begin
                s_d.st = CMS_CONV;
                s_d.sample = 1'b1;
            end
            CMS_CONV: begin
                if (slot.done) begin
                    s_d.sample = 1'b0;
                    s_d.valid[s_q.ch] = 1'b1;
                    if (n > `CMS_LAST_CH) begin
                        s_d.st = CMS_IDLE;
                        s_d.ch = `CMS_FIRST_CH;
                        s_d.busy = 1'b0;
                        s_d.seq_done = 1'b1;
                    end else begin
                        s_d.st = CMS_ACQ;
                        s_d.ch = n;
                    end
                end
            end
            default: begin
                s_d.st = CMS_IDLE;
            end
        endcase
        m = mux_of(s_d.ch);
        s_d.aux_sel = m[6];
        s_d.aux_idx = m[5:3];
        s_d.tap_hi = s_d.aux_sel ? 3'h6 : m[2:0];
        s_d.tap_lo = s_d.aux_sel ? 3'h5 : m[2:0] - 3'h1;
    end
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            s_q <= '{pin_sync: 2'h3, pin_prev: 1'b1, st: CMS_IDLE, tap_hi: 3'h6,
                     tap_lo: 3'h5, default: '0};
        end else if (i_ce) begin
            s_q <= s_d;
        end
    end
    // result store; straight binary code is taken as delivered
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            res_q <= '{default: '0};
        end else if (i_ce && wr_en) begin
            res_q[s_q.ch] <= i_adc_code;
        end
    end
    assign o_busy = s_q.busy;
    assign o_seq_done = s_q.seq_done;
    assign o_sample = s_q.sample;
    assign o_tap_hi = s_q.tap_hi;
    assign o_tap_lo = s_q.tap_lo;
    assign o_aux_sel = s_q.aux_sel;
    assign o_temp_sense_sel = s_q.aux_idx;
    assign o_result = res_q;
    assign o_result_valid = s_q.valid;

    int slot_len;
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n || s_q.st == CMS_IDLE) slot_len <= 0;
        else if (i_ce && s_q.st == CMS_ACQ) slot_len <= 1;
        else if (i_ce) slot_len <= slot_len + 1;
    end
    a_slot_min: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (wr_en && i_ce) |-> slot_len >= `CMS_CHAN_CYC - 1)
        else $error("channel slot shorter than minimum");
    a_first_cell: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (s_q.st == CMS_IDLE && s_d.st == CMS_ACQ && i_ce) |=> (o_tap_hi == 3'h6 &&
        o_tap_lo == 3'h5 && !o_aux_sel))
        else $error("sequence did not begin on cell 6");
    a_park_idle: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        $fell(o_busy) |-> (o_tap_hi == 3'h6 && o_tap_lo == 3'h5 && !o_aux_sel))
        else $error("mux not parked on cell 6");
    a_adjacent: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        !o_aux_sel |-> o_tap_hi == o_tap_lo + 3'h1)
        else $error("taps not adjacent");
    a_cells_only: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (i_channel_select_field == `CMS_SEL_CELLS) |-> !o_aux_sel)
        else $error("aux selected in cells-only mode");
    a_odd_aux: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (i_channel_select_field == `CMS_SEL_ODD && o_aux_sel) |-> !o_temp_sense_sel[0])
        else $error("even aux converted in odd mode");
    // a start seen mid-slot must leave the engine running on the same channel
    a_busy_ignore: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (s_q.st != CMS_IDLE && !wr_en && start_req && i_ce)
        |=> (s_q.st != CMS_IDLE && $stable(s_q.ch)))
        else $error("sequence restarted while busy");
    a_store: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (wr_en && i_ce) |=> o_result[$past(s_q.ch)] == $past(i_adc_code))
        else $error("code not stored in channel register");
    a_done_pulse: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        o_seq_done |-> !o_busy && $past(o_busy))
        else $error("done without a running sequence");
    a_pin_start: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (i_use_serial_start && s_q.st == CMS_IDLE && !i_serial_start && i_ce)
        |=> s_q.st == CMS_IDLE)
        else $error("pin start taken in serial mode");
    c_restart_ignored: cover property (@(posedge i_core_clk)
        s_q.st != CMS_IDLE && !wr_en && start_req && i_ce);
    c_full_seq: cover property (@(posedge i_core_clk) o_seq_done && o_result_valid == 12'hfff);
    c_cells_seq: cover property (@(posedge i_core_clk) o_seq_done && o_result_valid == 12'h03f);
    c_odd_seq: cover property (@(posedge i_core_clk) o_seq_done && o_result_valid == 12'h57f);
endmodule : cms_sequencer

// ==== testbench/cms_cell_model.sv ====
// far-side model: cell taps and auxiliary inputs feeding the converter code
`timescale 1ns/1ns
module cms_cell_model (
    input wire logic i_core_clk,
    input wire logic i_sample,
    input wire logic [2:0] i_tap_hi,
    input wire logic [2:0] i_tap_lo,
    input wire logic i_aux_sel,
    input wire logic [2:0] i_temp_sense_sel,
    output logic [11:0] o_adc_code
);
    logic [11:0] code;
    logic [11:0] last_q = 12'h000;
    // each tap pair or aux input gives its own code, so misrouting shows in the result
    always_comb begin
        if (i_aux_sel) begin
            code = {4'ha, 5'h00, i_temp_sense_sel};
        end else begin
            code = {4'hc, 1'b0, i_tap_hi, 1'b0, i_tap_lo};
        end
    end
    // outside conversion the line shows the inverse of the last value, never a stale match
    always_ff @(posedge i_core_clk) begin
        if (i_sample) begin
            last_q <= code;
        end
    end
    assign o_adc_code = i_sample ? code : ~last_q;
endmodule : cms_cell_model

// ==== testbench/testbench.sv ====
// self-checking bench for the conversion sequencer
`timescale 1ns/1ns
module testbench;
    logic clk = 1'b0, rst_n = 1'b0, pin_n = 1'b1, ser = 1'b0, use_ser = 1'b1;
    logic [1:0] sel = 2'h0;
    logic ce = 1'b1;
    logic busy, done, sample, aux, samp_q = 1'b0;
    logic [2:0] thi, tlo, asel;
    logic [11:0] code, valid;
    logic [11:0] res [12];
    int miscompares = 0, n_checks = 0, cycles = 0;
    int order_q[$];
    always #10 clk = ~clk;
    cms_sequencer u_dut (.i_core_clk(clk), .i_reset_n(rst_n), .i_ce(ce),
        .i_convert_start_n(pin_n), .i_serial_start(ser), .i_use_serial_start(use_ser),
        .i_channel_select_field(sel), .i_adc_code(code), .o_busy(busy), .o_seq_done(done),
        .o_sample(sample), .o_tap_hi(thi), .o_tap_lo(tlo), .o_aux_sel(aux),
        .o_temp_sense_sel(asel), .o_result(res), .o_result_valid(valid));
    cms_cell_model u_cells (.i_core_clk(clk), .i_sample(sample), .i_tap_hi(thi),
        .i_tap_lo(tlo), .i_aux_sel(aux), .i_temp_sense_sel(asel), .o_adc_code(code));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // record the channel at each conversion start; a cell reading must span adjacent taps
    always @(posedge clk) begin
        samp_q <= sample;
        if (sample && !samp_q) begin
            order_q.push_back(aux ? 6 + asel : 6 - thi);
            if (!aux) chk(thi, tlo + 3'h1);
        end
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : final_report
    // hang guard: whole run is well under this many cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            miscompares++;
            final_report();
        end
    end
    task automatic run_seq(input int tn, input logic [1:0] s, input logic by_ser,
                           input logic extra);
        logic [11:0] m, v0;
        int n, cyc, k;
        m = (s == 2'h0) ? 12'hfff : (s == 2'h1) ? 12'h57f : (s == 2'h2) ? 12'h03f : 12'h000;
        n = $countones(m);
        @(posedge clk);
        sel <= s;
        use_ser <= by_ser;
        repeat (4500) @(posedge clk);
        order_q.delete();
        v0 = valid;
        if (by_ser) ser <= 1'b1;
        else pin_n <= 1'b0;
        @(posedge clk);
        ser <= 1'b0;
        cyc = 0;
        while (!done && cyc < 1000) begin
            @(posedge clk);
            pin_n <= 1'b1;
            ser <= (extra && cyc == 60);
            cyc++;
        end
        #1;
        if (n == 0) begin
            chk(cyc, 1000);
        end else begin
            chk(cyc >= n * 50 && cyc <= n * 50 + 6, 1);
            chk(order_q.size(), n);
            if (order_q.size() > 0) chk(order_q[0], 0);
            k = 0;
            for (int i = 0; i < 12; i++) begin
                if (m[i] && k < order_q.size()) begin
                    chk(order_q[k], i);
                    k++;
                end
            end
        end
        repeat (250) @(posedge clk);
        #1;
        chk({busy, aux, thi, tlo}, {2'b00, 3'h6, 3'h5});
        chk(order_q.size(), n);
        // an ignored start leaves the flags of the last run untouched
        chk(valid, n == 0 ? v0 : m);
        for (int i = 0; i < 12; i++) begin
            if (m[i]) chk(res[i], i < 6 ? {4'hc, 1'b0, 3'(6 - i), 1'b0, 3'(5 - i)}
                                       : {4'ha, 5'h00, 3'(i - 6)});
        end
        $display("test %0d finished", tn);
    endtask : run_seq
    // serial mode must ignore the pin and pin mode the serial pulse; a runnable select
    // is set so that only the start source can keep the sequence from running
    task automatic pin_ignored();
        @(posedge clk);
        sel <= 2'h2;
        use_ser <= 1'b1;
        repeat (4500) @(posedge clk);
        pin_n <= 1'b0;
        repeat (20) @(posedge clk);
        pin_n <= 1'b1;
        #1;
        chk(busy, 1'b0);
        @(posedge clk);
        use_ser <= 1'b0;
        ser <= 1'b1;
        @(posedge clk);
        ser <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk(busy, 1'b0);
        $display("test 5 finished");
    endtask : pin_ignored
    // clock enable low freezes the run mid-slot; the run stretches by the frozen cycles
    task automatic ce_freeze();
        int cyc;
        @(posedge clk);
        use_ser <= 1'b1;
        ser <= 1'b1;
        @(posedge clk);
        ser <= 1'b0;
        repeat (20) @(posedge clk);
        ce <= 1'b0;
        @(posedge clk);
        #1;
        chk({busy, sample, thi, tlo}, {2'b11, 3'h6, 3'h5});
        repeat (100) @(posedge clk);
        #1;
        chk({busy, sample, thi, tlo}, {2'b11, 3'h6, 3'h5});
        @(posedge clk);
        ce <= 1'b1;
        cyc = 0;
        while (!done && cyc < 400) begin
            @(posedge clk);
            cyc++;
        end
        #1;
        chk(cyc >= 6 * 50 - 22 && cyc <= 6 * 50 - 18, 1);
        chk(valid, 12'h03f);
        $display("test 6 finished");
    endtask : ce_freeze
    // a reset in mid-run drops the sequence and parks the mux; a start right after runs whole
    task automatic reset_mid();
        int cyc;
        @(posedge clk);
        ser <= 1'b1;
        @(posedge clk);
        ser <= 1'b0;
        repeat (30) @(posedge clk);
        rst_n <= 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        chk({busy, sample, aux, thi, tlo, valid}, {3'b000, 3'h6, 3'h5, 12'h000});
        @(posedge clk);
        ser <= 1'b1;
        @(posedge clk);
        ser <= 1'b0;
        cyc = 0;
        while (!done && cyc < 400) begin
            @(posedge clk);
            cyc++;
        end
        #1;
        chk(cyc >= 6 * 50 && cyc <= 6 * 50 + 6, 1);
        chk(valid, 12'h03f);
        chk(res[5], {4'hc, 1'b0, 3'h1, 1'b0, 3'h0});
        $display("test 7 finished");
    endtask : reset_mid
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk({busy, thi, tlo}, {1'b0, 3'h6, 3'h5});
        run_seq(1, 2'h0, 1'b1, 1'b0);
        run_seq(2, 2'h1, 1'b0, 1'b0);
        run_seq(3, 2'h2, 1'b1, 1'b1);
        run_seq(4, 2'h3, 1'b1, 1'b0);
        pin_ignored();
        ce_freeze();
        reset_mid();
        final_report();
    end
endmodule : testbench
